// File: logic/qdr_map.vh
/*
 Constants of the quad gated register: register offsets, field positions,
 reset values and bus answer codes.
 Assumes inclusion by bare name from the design file of the block.
*/
`ifndef QDR_MAP_VH
`define QDR_MAP_VH

// ==========================================
// Register offsets (byte addresses)
`define QDR_CTRL_OFFSET 4'h0
`define QDR_STATUS_OFFSET 4'h4

// ==========================================
// Control register fields
`define QDR_CTRL_HOLD_BIT 0
`define QDR_CTRL_OUT_OFF_BIT 1
`define QDR_CTRL_RESET 2'h0

// ==========================================
// Status register fields
`define QDR_STAT_DATA_LSB 0
`define QDR_STAT_DATA_MSB 3
`define QDR_STAT_DRIVE_BIT 4
`define QDR_STAT_CLEAR_BIT 5

// ==========================================
// Reset values
`define QDR_STORE_RESET 4'h0
`define QDR_DATA_RESET 32'h0000_0000

// ==========================================
// Bus answer codes
`define QDR_RESP_OKAY 2'h0
`define QDR_RESP_SLVERR 2'h2

`endif

// File: logic/qdr_register.v
/*
 Quad edge-triggered register with a two-input active-low load gate, an
 active-high asynchronous clear and gated three-state output drive, plus an
 AXI4-Lite slave for a control and a status register.
 Assumes all inputs synchronous to sys_clk; the pad wire is resolved outside
 from bus_out_bit and bus_out_oe.
*/
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "qdr_map.vh"

module qdr_register #(
  parameter WIDTH = 4,
  parameter ADDR_W = 4
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Register pins
  input wire [WIDTH-1:0] parallel_in_bit,
  input wire load_gate_a_n,
  input wire load_gate_b_n,
  input wire async_clear,
  input wire out_gate_a_n,
  input wire out_gate_b_n,
  // Three-state output
  output wire [WIDTH-1:0] bus_out_bit,
  output reg [WIDTH-1:0] bus_out_oe,
  // AXI4-Lite write
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ==========================================
  // Storage
  localparam [WIDTH-1:0] STORE_INIT = `QDR_STORE_RESET;

  reg [WIDTH-1:0] stored;
  reg soft_hold;
  reg soft_out_off;
  wire gates_low;
  wire load_now;
  wire drive_on;

  // ==========================================
  // Load and drive decisions
  assign gates_low = ~load_gate_a_n & ~load_gate_b_n;
  assign load_now = gates_low & ~soft_hold;
  assign drive_on = ~out_gate_a_n & ~out_gate_b_n & ~soft_out_off;
  assign bus_out_bit = stored;

  always @(posedge sys_clk or negedge nrst or posedge async_clear) begin
    if (!nrst) begin
      stored <= STORE_INIT;
    end else if (async_clear) begin
      stored <= STORE_INIT;
    end else if (load_now) begin
      stored <= parallel_in_bit;
    end
  end

  // ==========================================
  // Output drive
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bus_out_oe <= {WIDTH{1'b0}};
    end else begin
      bus_out_oe <= {WIDTH{drive_on}};
    end
  end

  // ==========================================
  // Write channel
  reg aw_held;
  reg w_held;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg next_aw_held;
  reg next_w_held;
  reg next_bvalid;
  reg do_wr;
  wire wr_ctrl;
  wire wr_mapped;
  wire aw_take;
  wire w_take;

  // ==========================================
  // Write decode
  assign wr_ctrl = (aw_addr == `QDR_CTRL_OFFSET);
  assign wr_mapped = wr_ctrl | (aw_addr == `QDR_STATUS_OFFSET);
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;

  always @* begin
    do_wr = aw_held & w_held & ~s_axi_bvalid;
    next_aw_held = aw_held | aw_take;
    next_w_held = w_held | w_take;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    if (do_wr) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
    end
  end

  // ==========================================
  // Write register
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_data <= `QDR_DATA_RESET;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `QDR_RESP_OKAY;
      soft_hold <= 1'b0;
      soft_out_off <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_bvalid <= next_bvalid;
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready <= ~next_w_held & ~next_bvalid;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bresp <= wr_mapped ? `QDR_RESP_OKAY : `QDR_RESP_SLVERR;
        if (wr_ctrl && w_strb[0]) begin
          soft_hold <= w_data[`QDR_CTRL_HOLD_BIT];
          soft_out_off <= w_data[`QDR_CTRL_OUT_OFF_BIT];
        end
      end
    end
  end

  // ==========================================
  // Read channel
  reg next_rvalid;
  reg [31:0] rd_word;
  reg [1:0] rd_resp;
  wire rd_take;

  assign rd_take = s_axi_arvalid & s_axi_arready;

  // ==========================================
  // Read decode

  always @* begin
    rd_word = `QDR_DATA_RESET;
    rd_resp = `QDR_RESP_OKAY;
    case (s_axi_araddr)
      `QDR_CTRL_OFFSET: begin
        rd_word[`QDR_CTRL_HOLD_BIT] = soft_hold;
        rd_word[`QDR_CTRL_OUT_OFF_BIT] = soft_out_off;
      end
      `QDR_STATUS_OFFSET: begin
        rd_word[`QDR_STAT_DATA_MSB:`QDR_STAT_DATA_LSB] = stored;
        rd_word[`QDR_STAT_DRIVE_BIT] = bus_out_oe[0];
        rd_word[`QDR_STAT_CLEAR_BIT] = async_clear;
      end
      default: begin
        rd_resp = `QDR_RESP_SLVERR;
      end
    endcase
    next_rvalid = (s_axi_rvalid & ~s_axi_rready) | rd_take;
  end

  // ==========================================
  // Read register
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `QDR_DATA_RESET;
      s_axi_rresp <= `QDR_RESP_OKAY;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (rd_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_resp;
      end
    end
  end

endmodule // qdr_register

// File: verification/qdr_register_assertions.sv
/* Checker of qdr_register pins and bus answers.
 Assumes it is bound into qdr_register. */
`timescale 1ns/10ps
module qdr_register_assertions #(parameter WIDTH = 4) (
  input wire sys_clk, nrst, load_gate_a_n, load_gate_b_n, async_clear,
  input wire out_gate_a_n, out_gate_b_n, s_axi_arvalid, s_axi_arready,
  input wire s_axi_rvalid, s_axi_rready, s_axi_bvalid, s_axi_bready,
  input wire [WIDTH-1:0] bus_out_bit,
  input wire [WIDTH-1:0] bus_out_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence gate_shut; load_gate_a_n || load_gate_b_n; endsequence
  gate_hold_a: assert property (gate_shut and !async_clear |=>
    async_clear || $stable(bus_out_bit)) else $error("held bits moved");
  clear_zero_a: assert property (async_clear |-> bus_out_bit == 0)
    else $error("clear ignored");
  oe_off_a: assert property (out_gate_a_n || out_gate_b_n |=> bus_out_oe == 0)
    else $error("outputs not floated");
  oe_equal_a: assert property (bus_out_oe == 0 || &bus_out_oe)
    else $error("enables split");
  clear_stay_a: assert property (async_clear ##1 (!async_clear and gate_shut)
    |=> bus_out_bit == 0) else $error("bits not kept zero");
  read_answer_a: assert property (ar_take |=> s_axi_rvalid) else $error("no read data");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data stuck");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
endmodule // qdr_register_assertions
bind qdr_register qdr_register_assertions #(.WIDTH(WIDTH)) u_chk (.*);

// File: verification/qdr_bus_model.sv
/* Shared bus beyond the three-state outputs.
 Assumes enables high while driving; a released bus shows the inverse. */
`timescale 1ns/10ps
module qdr_bus_model (
  input wire sys_clk,
  input wire [3:0] bus_out_bit,
  input wire [3:0] bus_out_oe,
  output wire [3:0] pad
);
  logic [3:0] last = 4'h0;
  always @(posedge sys_clk) if (&bus_out_oe) last <= bus_out_bit;
  assign pad = &bus_out_oe ? bus_out_bit : ~last;
endmodule // qdr_bus_model

// File: verification/qdr_register_tb.sv
/* Bench of qdr_register against an integer model.
 Assumes the bound checker and the bus model. */
`timescale 1ns/10ps
module qdr_register_tb;
  logic sys_clk = 0, nrst = 0, load_gate_a_n = 1, load_gate_b_n = 1, async_clear = 0;
  logic out_gate_a_n = 1, out_gate_b_n = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] parallel_in_bit = 0, s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0, s = 80, rsp, dat;
  wire [3:0] bus_out_bit, bus_out_oe, pad;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int error_cnt = 0, tests_run = 0, m = 0, e = 0, hold = 0, off = 0;
  qdr_register dut (.*);
  qdr_bus_model bus (.sys_clk, .bus_out_bit, .bus_out_oe, .pad);
  always #5 sys_clk = ~sys_clk;
  function logic [31:0] xs;
    s ^= s << 13; s ^= s >> 17; s ^= s << 5;
    return s;
  endfunction
  task chk(input logic [31:0] v, input logic [31:0] x);
    tests_run++;
    if (v !== x) begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, v, x);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin s_axi_bready <= 0; rsp = s_axi_bresp; end
    end while (s_axi_bready);
  endtask
  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin s_axi_rready <= 0; dat = s_axi_rdata; rsp = s_axi_rresp; end
    end while (s_axi_rready);
  endtask
  task ctl(input logic [31:0] v);
    @(posedge sys_clk) async_clear <= 1;
    wr(0, v); chk(rsp, 0);
    hold = v[0]; off = v[1];
  endtask
  task run(input int n);
    logic [31:0] r;
    repeat (n) begin
      @(posedge sys_clk);
      if (async_clear) m = 0;
      else if (!load_gate_a_n && !load_gate_b_n && !hold) m = parallel_in_bit;
      e = (!out_gate_a_n && !out_gate_b_n && !off) ? 15 : 0;
      r = xs();
      parallel_in_bit <= r[3:0]; load_gate_a_n <= r[4] & r[5]; load_gate_b_n <= r[6] & r[7];
      out_gate_a_n <= r[8] & r[9]; out_gate_b_n <= r[10]; async_clear <= r[15:12] == 0;
      if (r[15:12] == 0) m = 0;
      #1 chk(bus_out_bit, m);
      chk(bus_out_oe, e);
      if (e) chk(pad, m);
    end
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1;
    run(40);
    ctl(3);
    rd(4); chk(dat, 32'h0000_0020);
    rd(0); chk(dat, 32'h0000_0003);
    rd(8); chk(rsp, 2);
    wr(8, 1); chk(rsp, 2);
    run(30);
    ctl(0);
    run(30);
    conclude;
  end
  initial begin
    #5000 error_cnt++;
    conclude;
  end
endmodule // qdr_register_tb
